// [core/frame_host_ctrl.sv]
// processor end: starts synthesis and feeds one parameter set per frame interrupt
module frame_host_ctrl (
  input wire logic clk,
  input wire logic rst,
  synth_link_if.host link,
  input wire logic start,
  input wire logic [7:0] start_pitch,
  input wire logic [7:0] frame_prescale,
  input wire logic frame_interp,
  input wire logic frame_voiced,
  input wire logic word_valid,
  input wire logic [7:0] word_data,
  output logic word_ready,
  output logic busy
);
  import synth_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_PRESC, H_TIMER, H_START, H_WAIT, H_WRITE, H_VOICE, H_INTERP} host_st_t;
  typedef struct packed {
    host_st_t st;
    logic [4:0] idx;
    logic int_en;
  } host_state_t;

  host_state_t state_reg;
  host_state_t state_next;

  always_comb begin
    state_next = state_reg;
    link.cpu_we = 1'b0;
    link.cpu_addr = 8'h00;
    link.cpu_wdata = word_data;
    link.acc = 8'h00;
    link.interp_enable_instr = 1'b0;
    link.voicing_load_instr = 1'b0;
    link.timer_load_instr = 1'b0;
    link.prescale_load_instr = 1'b0;
    link.start_instr = 1'b0;
    link.irq_ack = 1'b0;
    word_ready = 1'b0;
    unique case (state_reg.st)
      H_IDLE: begin
        if (start) begin
          state_next.st = H_PRESC;
        end
      end
      H_PRESC: begin
        link.prescale_load_instr = 1'b1;
        link.acc = frame_prescale;
        state_next.st = H_TIMER;
      end
      H_TIMER: begin
        link.timer_load_instr = 1'b1;
        link.acc = TIMER_PRESET;
        state_next.st = H_START;
      end
      H_START: begin
        link.start_instr = 1'b1;
        link.acc = start_pitch;
        state_next.int_en = 1'b1;
        state_next.st = H_WAIT;
      end
      H_WAIT: begin
        if (link.irq_req) begin
          link.irq_ack = 1'b1;
          link.timer_load_instr = 1'b1;
          link.acc = TIMER_PRESET;
          state_next.idx = 5'h00;
          state_next.st = H_WRITE;
        end
      end
      H_WRITE: begin
        word_ready = 1'b1;
        link.cpu_addr = (state_reg.idx < BYTE_PARAMS) ? NEW_BYTE_BASE + {3'h0, state_reg.idx} :
          NEW_NIB_BASE + {3'h0, state_reg.idx - BYTE_PARAMS};
        if (word_valid) begin
          link.cpu_we = 1'b1;
          state_next.idx = state_reg.idx + 5'h01;
          if (state_reg.idx == ALL_PARAMS - 5'h01) begin
            state_next.st = H_VOICE;
          end
        end
      end
      H_VOICE: begin
        link.voicing_load_instr = 1'b1;
        link.acc = {7'h00, frame_voiced};
        state_next.st = H_INTERP;
      end
      H_INTERP: begin
        link.interp_enable_instr = frame_interp;
        state_next.st = H_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.st <= H_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign link.int_enable = state_reg.int_en;
  assign busy = state_reg.st != H_IDLE;
endmodule

// [core/frame_synth_ctrl.sv]
// synthesizer end: shared RAM, context swap, frame timer, interpolator, voicing, PWM output
// Summary of operation
// - RAM: 128 bytes plus 16 nibbles, processor access
// - synthesizer reads only 00-17 and 80-8F
// - frame interrupt swaps present and new sets
// - swap affects only the parameter region
// - without interp enable, present set used unchanged
// - swap still happens; interpolation stays off
// - interp enabled: per pitch period interpolate, load
// - timer value gives elapsed frame time
// - processor writes new set, then enables interp
// - sample rate 8 or 10 kHz via oscillator
// - voicing load copies accumulator bit zero
// - voicing change waits for next frame boundary
// - processor presets timer to 1F during synthesis
// - frame is 1536 times N+1 oscillator periods
// - interrupt routine reloads timer first
// - reset held long enough by outside party
// - samples drive complementary PWM speaker outputs
// - timer decrements on prescaler wrap, interrupts pending
// - prescaler reloads from preset on wrap
// - prescaler clock is oscillator divided by 48
// - start loads pitch from accumulator, then RAM
module frame_synth_ctrl (
  input wire logic clk,
  input wire logic rst,
  synth_link_if.device link,
  input wire logic [7:0] filter_sample,
  output logic [7:0] param_data,
  output logic [4:0] param_index,
  output logic param_valid,
  output logic voiced,
  output logic frame_tick,
  output logic speaker_out_a,
  output logic speaker_out_b
);
  import synth_pkg::*;

  typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_t;
  typedef struct packed {
    seq_t seq;
    logic synth_on;
    logic bank;
    logic interp_on;
    logic voicing_reg;
    logic voicing_arm;
    logic voicing_hold;
    logic voiced;
    logic [7:0] pitch;
    logic [7:0] pitch_cnt;
    logic [8:0] sample_cnt;
    logic [5:0] div_cnt;
    logic [7:0] presc;
    logic [7:0] presc_preset;
    logic [7:0] timer;
    logic timer_run;
    logic irq_pend;
    logic frame_tick;
    logic [4:0] idx;
    logic [7:0] param_data;
    logic [4:0] param_index;
    logic param_valid;
    logic [7:0] rdata;
    logic [7:0] pwm_cnt;
    logic [7:0] pwm_level;
    logic pwm_a;
    logic pwm_b;
  } dev_state_t;

  dev_state_t state_reg;
  dev_state_t state_next;

  logic [7:0] byte_mem [BYTE_WORDS];
  logic [3:0] nib_mem [NIB_WORDS];

  // logical to physical address; only the parameter region is remapped
  function automatic logic [7:0] map_addr(input logic [7:0] a, input logic bank);
    logic [7:0] m;
    m = a;
    if (bank && a <= BYTE_PARAM_LAST) begin
      m = (a < BYTE_SET_SIZE) ? a + BYTE_SET_SIZE : a - BYTE_SET_SIZE;
    end else if (bank && a >= NIB_BASE && a <= NIB_LAST) begin
      m = a ^ NIB_SET_BIT;
    end
    return m;
  endfunction

  function automatic logic [7:0] read_mem(input logic [7:0] p);
    logic [7:0] v;
    v = 8'h00;
    if (p < NIB_BASE) begin
      v = byte_mem[p[6:0]];
    end else if (p <= NIB_LAST) begin
      v = {4'h0, nib_mem[p[3:0]]};
    end
    return v;
  endfunction

  logic [7:0] cpu_phys;
  logic [7:0] pres_addr;
  logic [7:0] new_addr;
  logic [7:0] pres_val;
  logic [7:0] new_val;
  logic [4:0] elapsed;
  logic signed [8:0] diff;
  logic signed [14:0] scaled;
  logic [7:0] interp_val;
  logic [7:0] pitch_mem;

  always_comb begin
    cpu_phys = map_addr(link.cpu_addr, state_reg.bank);
    // synthesizer reads stay within 00-17 and 80-8F
    if (state_reg.idx < BYTE_PARAMS) begin
      pres_addr = map_addr({3'h0, state_reg.idx}, state_reg.bank);
      new_addr = map_addr(NEW_BYTE_BASE + {3'h0, state_reg.idx}, state_reg.bank);
    end else begin
      pres_addr = map_addr(NIB_BASE + {3'h0, state_reg.idx - BYTE_PARAMS}, state_reg.bank);
      new_addr = map_addr(NEW_NIB_BASE + {3'h0, state_reg.idx - BYTE_PARAMS}, state_reg.bank);
    end
    pres_val = read_mem(pres_addr);
    new_val = read_mem(new_addr);
    pitch_mem = read_mem(map_addr(PITCH_ADDR, state_reg.bank));
    elapsed = TIMER_PRESET[4:0] - state_reg.timer[4:0];
    diff = $signed({1'b0, new_val}) - $signed({1'b0, pres_val});
    scaled = diff * $signed({1'b0, elapsed});
    interp_val = pres_val + 8'(scaled >>> 5);
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (link.cpu_we) begin
      if (cpu_phys < NIB_BASE) begin
        byte_mem[cpu_phys[6:0]] <= link.cpu_wdata;
      end else if (cpu_phys <= NIB_LAST) begin
        nib_mem[cpu_phys[3:0]] <= link.cpu_wdata[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic presc_tick;
  logic presc_wrap;
  logic frame_evt;
  logic sample_tick;
  logic pitch_evt;

  always_comb begin
    state_next = state_reg;
    state_next.rdata = read_mem(cpu_phys);
    state_next.param_valid = 1'b0;
    state_next.frame_tick = 1'b0;

    // prescaler clock at oscillator/48
    presc_tick = (state_reg.div_cnt == PRESCALE_DIV - 6'h01);
    state_next.div_cnt = presc_tick ? 6'h00 : state_reg.div_cnt + 6'h01;
    presc_wrap = presc_tick && state_reg.presc == 8'h00;
    if (presc_tick) begin
      state_next.presc = presc_wrap ? state_reg.presc_preset : state_reg.presc - 8'h01;
    end
    if (link.prescale_load_instr) begin
      state_next.presc_preset = link.acc;
    end

    // frame timer, stops after its own wrap until reloaded
    frame_evt = presc_wrap && state_reg.timer_run && state_reg.timer == 8'h00;
    if (presc_wrap && state_reg.timer_run) begin
      state_next.timer = state_reg.timer - 8'h01;
    end
    if (frame_evt) begin
      state_next.timer_run = 1'b0;
      state_next.bank = ~state_reg.bank;
      state_next.interp_on = 1'b0;
      state_next.voicing_arm = 1'b1;
      // freeze the value loaded during the ending frame; later loads wait a frame
      state_next.voicing_hold = state_reg.voicing_reg;
      state_next.frame_tick = 1'b1;
    end
    if (link.timer_load_instr) begin
      state_next.timer = link.acc;
      state_next.timer_run = 1'b1;
    end
    if (link.irq_ack) begin
      state_next.irq_pend = 1'b0;
    end
    if (frame_evt) begin
      state_next.irq_pend = 1'b1;
    end
    if (link.interp_enable_instr) begin
      state_next.interp_on = 1'b1;
    end
    if (link.voicing_load_instr) begin
      state_next.voicing_reg = link.acc[0];
    end

    // sample clock: oscillator periods per sample set the 8 or 10 kHz rate
    sample_tick = (state_reg.sample_cnt == OSC_PER_SAMPLE - 9'h001);
    state_next.sample_cnt = sample_tick ? 9'h000 : state_reg.sample_cnt + 9'h001;
    pitch_evt = sample_tick && state_reg.synth_on && state_reg.pitch_cnt == 8'h00;
    if (sample_tick && state_reg.synth_on) begin
      state_next.pitch_cnt = pitch_evt ? state_reg.pitch : state_reg.pitch_cnt - 8'h01;
    end
    if (link.start_instr) begin
      state_next.synth_on = 1'b1;
      state_next.pitch = link.acc;
      state_next.pitch_cnt = link.acc;
    end

    // parameter walk, one parameter a cycle, started on pitch boundaries only
    unique case (state_reg.seq)
      SEQ_IDLE: begin
        if (pitch_evt) begin
          state_next.seq = SEQ_RUN;
          state_next.idx = 5'h00;
          state_next.pitch = pitch_mem;
          // a boundary in this very cycle makes this the new frame's first update
          if (frame_evt || state_reg.voicing_arm) begin
            state_next.voiced = frame_evt ? state_reg.voicing_reg : state_reg.voicing_hold;
            state_next.voicing_arm = 1'b0;
          end
        end
      end
      SEQ_RUN: begin
        state_next.param_data = state_reg.interp_on ? interp_val : pres_val;
        state_next.param_index = state_reg.idx;
        state_next.param_valid = 1'b1;
        state_next.idx = state_reg.idx + 5'h01;
        if (state_reg.idx == ALL_PARAMS - 5'h01) begin
          state_next.seq = SEQ_IDLE;
        end
      end
    endcase

    // complementary PWM of the filter sample
    state_next.pwm_cnt = state_reg.pwm_cnt + 8'h01;
    if (state_reg.pwm_cnt == 8'hFF) begin
      state_next.pwm_level = filter_sample;
    end
    state_next.pwm_a = state_reg.pwm_cnt < state_reg.pwm_level;
    state_next.pwm_b = ~(state_reg.pwm_cnt < state_reg.pwm_level);
    if (!state_reg.synth_on) begin
      state_next.pwm_a = 1'b0;
      state_next.pwm_b = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.seq <= SEQ_IDLE;
      state_reg.presc_preset <= RESET_PRESET;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign link.cpu_rdata = state_reg.rdata;
  assign link.irq_req = state_reg.irq_pend && link.int_enable;
  assign param_data = state_reg.param_data;
  assign param_index = state_reg.param_index;
  assign param_valid = state_reg.param_valid;
  assign voiced = state_reg.voiced;
  assign frame_tick = state_reg.frame_tick;
  assign speaker_out_a = state_reg.pwm_a;
  assign speaker_out_b = state_reg.pwm_b;
endmodule

// [core/synth_link_if.sv]
// processor-to-synthesizer link: shared RAM port and instruction strobes
interface synth_link_if;
  logic cpu_we;
  logic [7:0] cpu_addr;
  logic [7:0] cpu_wdata;
  logic [7:0] cpu_rdata;
  logic [7:0] acc;
  logic interp_enable_instr;
  logic voicing_load_instr;
  logic timer_load_instr;
  logic prescale_load_instr;
  logic start_instr;
  logic int_enable;
  logic irq_req;
  logic irq_ack;
  modport device (input cpu_we, cpu_addr, cpu_wdata, acc, interp_enable_instr, voicing_load_instr,
    timer_load_instr, prescale_load_instr, start_instr, int_enable, irq_ack, output cpu_rdata, irq_req);
  modport host (output cpu_we, cpu_addr, cpu_wdata, acc, interp_enable_instr, voicing_load_instr,
    timer_load_instr, prescale_load_instr, start_instr, int_enable, irq_ack, input cpu_rdata, irq_req);
endinterface

// [core/synth_pkg.sv]
// shared constants for the speech frame control ends
package synth_pkg;
  localparam int CLK_MHZ = 200;
  localparam int BYTE_WORDS = 128;
  localparam int NIB_WORDS = 16;
  localparam logic [7:0] NIB_BASE = 8'h80;
  localparam logic [7:0] NIB_LAST = 8'h8F;
  localparam logic [7:0] BYTE_PARAM_LAST = 8'h17;
  localparam logic [7:0] BYTE_SET_SIZE = 8'h0C;
  localparam logic [7:0] NIB_SET_BIT = 8'h08;
  localparam logic [7:0] NEW_BYTE_BASE = 8'h0C;
  localparam logic [7:0] NEW_NIB_BASE = 8'h88;
  localparam logic [4:0] BYTE_PARAMS = 5'h0C;
  localparam logic [4:0] ALL_PARAMS = 5'h14;
  localparam logic [7:0] TIMER_PRESET = 8'h1F;
  localparam logic [5:0] PRESCALE_DIV = 6'h30;
  localparam logic [8:0] OSC_PER_SAMPLE = 9'h180;
  localparam logic [7:0] PITCH_ADDR = 8'h00;
  localparam logic [7:0] RESET_PRESET = 8'h00;
endpackage

// [dv/speech_frame_synth_control_tb_top.sv]
// bench: host end and synthesizer end joined by the link
module speech_frame_synth_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, start = 1'b0, frame_interp = 1'b0, frame_voiced = 1'b0, word_valid = 1'b0;
  logic [7:0] word_data = 8'h00, filt = 8'h80, param_data;
  logic [4:0] param_index;
  logic param_valid, voiced, frame_tick, spk_a, spk_b, word_ready, busy;
  logic mixed = 1'b1, fresh = 1'b0, v_cur = 1'b0, v_lat = 1'b0, v_nxt = 1'b0, voiced_d = 1'b0;
  logic [7:0] seen [20];
  int err_total = 0, num_checks = 0, ticks = 0, walks = 0, cyc = 0, mode = 0, eset = 0, moved = 0, s_nxt = 0;
  synth_link_if link ();
  frame_synth_ctrl frame_synth_ctrl_inst (.clk(clk), .rst(rst), .link(link.device), .filter_sample(filt),
    .param_data(param_data), .param_index(param_index), .param_valid(param_valid), .voiced(voiced),
    .frame_tick(frame_tick), .speaker_out_a(spk_a), .speaker_out_b(spk_b));
  frame_host_ctrl frame_host_ctrl_inst (.clk(clk), .rst(rst), .link(link.host), .start(start),
    .start_pitch(8'h09), .frame_prescale(8'h00), .frame_interp(frame_interp), .frame_voiced(frame_voiced),
    .word_valid(word_valid), .word_data(word_data), .word_ready(word_ready), .busy(busy));
  synth_link_asserts #(.FRAME_N(0)) synth_link_asserts_inst (.clk(clk), .rst(rst), .cpu_we(link.cpu_we),
    .cpu_addr(link.cpu_addr), .cpu_rdata(link.cpu_rdata), .acc(link.acc),
    .interp_enable_instr(link.interp_enable_instr), .voicing_load_instr(link.voicing_load_instr),
    .timer_load_instr(link.timer_load_instr), .prescale_load_instr(link.prescale_load_instr),
    .start_instr(link.start_instr), .int_enable(link.int_enable), .irq_req(link.irq_req), .irq_ack(link.irq_ack));
  //////////////////////////////////////////////////////////////////////////////
  // set 0 rises to set 1 by 8'h40 per byte; pitch word kept equal
  function automatic logic [7:0] pv(input int s, input int i);
    if (i == 0) return 8'h02;
    if (i < 12) return (s != 0 ? 8'h50 : 8'h10) + 8'(i);
    return s != 0 ? 8'h09 : 8'h01;
  endfunction
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wait_tick();
    int t;
    t = ticks;
    while (ticks == t) @(posedge clk);
  endtask
  task automatic send_set(input int s, input logic interp, input logic vc);
    frame_interp <= interp;
    frame_voiced <= vc;
    for (int i = 0; i < 20; i++) begin
      word_valid <= 1'b1;
      word_data <= pv(s, i);
      @(posedge clk iff word_ready);
    end
    word_valid <= 1'b0;
    v_nxt = vc;
    s_nxt = s;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // walks cut by a frame boundary are skipped; a set sent in one frame is present in the next
  always @(posedge clk) begin
    cyc <= cyc + 1;
    voiced_d <= voiced;
    if (frame_tick) begin
      ticks <= ticks + 1;
      fresh <= 1'b1;
      v_lat <= v_nxt;
      eset <= s_nxt;
      chk("voiced at boundary", {7'h00, voiced_d}, {7'h00, v_cur});
    end
    if (param_valid) begin
      seen[param_index] = param_data;
      if (param_index == 5'h00) mixed <= frame_tick;
      else if (frame_tick) mixed <= 1'b1;
      if (param_index == 5'h13 && !mixed && !frame_tick) begin
        walks <= walks + 1;
        filt <= filt + 8'h1D;
        chk("speaker pair", {7'h00, spk_a ^ spk_b}, 8'h01);
        if (fresh) begin
          chk("voiced after update", {7'h00, voiced}, {7'h00, v_lat});
          v_cur <= v_lat;
          fresh <= 1'b0;
        end
        if (mode == 2 && seen[1] !== pv(0, 1)) moved <= 1;
        for (int i = 0; i < 20; i++) begin
          if (mode == 1) chk("param", seen[i], pv(eset, i));
          if (mode == 2) chk("interp range", {7'h00, seen[i] >= pv(0, i) && seen[i] <= pv(1, i)}, 8'h01);
        end
      end
    end
  end
  task automatic test_frame_span();
    int t0;
    wait_tick();
    t0 = cyc;
    send_set(0, 1'b0, 1'b1);
    wait_tick();
    chk("frame span", {7'h00, cyc - t0 >= 1488 && cyc - t0 <= 1600}, 8'h01);
    chk("busy running", {7'h00, busy}, 8'h01);
    $display("frame span test done");
  endtask
  task automatic test_interp();
    mode = 2;
    send_set(1, 1'b1, 1'b0);
    wait_tick();
    chk("interp moved", 8'(moved), 8'h01);
    $display("interpolation test done");
  endtask
  task automatic test_plain_frames();
    int w;
    mode = 1;
    send_set(0, 1'b0, 1'b0);
    wait_tick();
    send_set(1, 1'b0, 1'b1);
    w = walks;
    while (walks < w + 2) @(posedge clk);
    $display("plain frame test done");
  endtask
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    #100us;
    err_total++;
    $display("FAIL watchdog expected finish seen hang");
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    chk("speakers idle", {6'h00, spk_a, spk_b}, 8'h00);
    chk("busy idle", {7'h00, busy}, 8'h00);
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    test_frame_span();
    test_interp();
    test_plain_frames();
    print_verdict();
  end
endmodule

// [dv/synth_link_asserts.sv]
// link checker: frame interrupt timing, reload order and write order
module synth_link_asserts
  import synth_pkg::*;
#(parameter int FRAME_N = 0) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cpu_we,
  input wire logic [7:0] cpu_addr,
  input wire logic [7:0] cpu_rdata,
  input wire logic [7:0] acc,
  input wire logic interp_enable_instr,
  input wire logic voicing_load_instr,
  input wire logic timer_load_instr,
  input wire logic prescale_load_instr,
  input wire logic start_instr,
  input wire logic int_enable,
  input wire logic irq_req,
  input wire logic irq_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  // span: cycles since the last timer preset; writes: ram writes since the last ack
  typedef struct packed {logic [15:0] span; logic [7:0] writes;} track_t;
  localparam int FRAME_LO = 1488 * (FRAME_N + 1);
  localparam int FRAME_HI = 1536 * (FRAME_N + 1) + 64;
  track_t st_reg, st_next;
  always_comb begin
    st_next = st_reg;
    st_next.span = timer_load_instr ? 16'h0000 : st_reg.span + 16'h0001;
    st_next.writes = irq_ack ? 8'h00 : st_reg.writes + {7'h00, cpu_we};
  end
  always_ff @(posedge clk) begin
    st_reg <= rst ? '0 : st_next;
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ack_reloads_a: assert property (irq_ack |-> timer_load_instr)
    else $error("ack without timer reload");
  preset_value_a: assert property (timer_load_instr |-> acc == TIMER_PRESET)
    else $error("timer preset not 1F");
  new_region_a: assert property (cpu_we |-> cpu_addr inside {[NEW_BYTE_BASE:BYTE_PARAM_LAST], [NEW_NIB_BASE:NIB_LAST]})
    else $error("write outside next set");
  ack_clears_a: assert property (irq_ack |=> !irq_req)
    else $error("request kept after ack");
  req_gated_a: assert property (irq_req |-> int_enable)
    else $error("request while disabled");
  frame_span_a: assert property ($rose(irq_req) |-> st_reg.span >= FRAME_LO && st_reg.span <= FRAME_HI)
    else $error("frame length wrong");
  voice_order_a: assert property (voicing_load_instr |-> st_reg.writes == 8'h14)
    else $error("voicing before all words");
  interp_order_a: assert property (interp_enable_instr |-> st_reg.writes == 8'h14 && !cpu_we)
    else $error("interp enable before all words");
  start_seq_a: assert property (start_instr |-> $past(timer_load_instr) && $past(prescale_load_instr, 2))
    else $error("start without presets");
  nibble_width_a: assert property (cpu_addr inside {[NIB_BASE:NIB_LAST]} |=> cpu_rdata[7:4] == 4'h0)
    else $error("nibble word wider than 4 bits");
  cover property (irq_ack);
  cover property (voicing_load_instr);
  cover property (interp_enable_instr);
endmodule
